// >>> tsec_pkg.sv
// Constants, types and register map of the two-stage event controller
package tsec_pkg;

	// ----------------------------------------------------------------
	// Sizes
	// ----------------------------------------------------------------
	localparam int NUM_SRC        = 32;
	localparam int NUM_EVT        = 16;
	localparam int NUM_DED        = 7;
	localparam int NUM_GP         = 9;
	localparam int GP_FIRST       = 7;
	localparam int ASSIGN_W       = 4;
	localparam int SRC_PER_ASSIGN = 8;
	localparam int NUM_ASSIGN_REG = 4;

	// ----------------------------------------------------------------
	// Register byte offsets
	// ----------------------------------------------------------------
	localparam logic [11:0] OFS_PERIPH_MASK   = 12'h000;
	localparam logic [11:0] OFS_PERIPH_STATUS = 12'h004;
	localparam logic [11:0] OFS_PERIPH_WAKE   = 12'h008;
	localparam logic [11:0] OFS_FORWARDED     = 12'h00c;
	localparam logic [11:0] OFS_ASSIGN0       = 12'h010;
	localparam logic [11:0] OFS_CORE_LATCH    = 12'h020;
	localparam logic [11:0] OFS_CORE_MASK     = 12'h024;
	localparam logic [11:0] OFS_CORE_PENDING  = 12'h028;
	localparam logic [11:0] OFS_GLOBAL_EN     = 12'h02c;

	// ----------------------------------------------------------------
	// Reset values and fixed fields
	// ----------------------------------------------------------------
	localparam logic [31:0]        RST_PERIPH_MASK = 32'h0;
	localparam logic [31:0]        RST_PERIPH_WAKE = 32'h0;
	localparam logic [31:0]        RST_ASSIGN      = 32'h0;
	localparam logic [NUM_EVT-1:0] RST_CORE_MASK   = 16'h0;
	localparam logic               RST_GLOBAL_EN   = 1'b0;
	// Emulation, reset, NMI and exception cannot be masked
	localparam logic [NUM_EVT-1:0] DED_UNMASKED    = 16'h000f;
	// Level 4 is reserved and never latches
	localparam logic [NUM_EVT-1:0] EVT_VALID       = 16'hffef;
	localparam logic [NUM_EVT-1:0] GP_LEVELS       = 16'hff80;
	localparam logic [NUM_EVT-1:0] EVT_ONE         = 16'h1;
	localparam logic [NUM_GP-1:0]  GP_ONE          = 9'h1;

	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	localparam logic [1:0] RESP_DECERR = 2'b11;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		WR_IDLE = 2'b01,
		WR_RESP = 2'b10
	} tsec_wr_e;

	typedef struct packed {
		logic       valid;
		logic [3:0] level;
	} tsec_entry_s;

endpackage : tsec_pkg

// >>> tsec_edge_detect.sv
// Two-cycle rising edge detector, one lane per event input
`timescale 1ns/100ps
module tsec_edge_detect #(
	parameter int W = 16
) (
	input  wire logic         clk,      // Core clock
	input  wire logic         rst_n,    // Synchronised reset, active low
	input  wire logic [W-1:0] level_in, // Event levels, same clock
	output logic      [W-1:0] rise      // One-cycle rise pulse per lane
);

	logic [W-1:0] stage_a;
	logic [W-1:0] stage_b;
	logic [W-1:0] next_stage_a;
	logic [W-1:0] next_stage_b;

	// ----------------------------------------------------------------
	// Per-lane detection
	// ----------------------------------------------------------------
	genvar g;
	for (g = 0; g < W; g++) begin : g_lane
		assign next_stage_a[g] = level_in[g];
		assign next_stage_b[g] = stage_a[g];
		assign rise[g]         = stage_a[g] & ~stage_b[g];
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			stage_a <= '0;
			stage_b <= '0;
		end else begin
			stage_a <= next_stage_a;
			stage_b <= next_stage_b;
		end
	end

endmodule : tsec_edge_detect

// >>> tsec_core_top.sv
// Two-stage event controller: peripheral stage, core stage, AXI4-Lite slave
//
// Implementation choices: register access over AXI4-Lite and the address map.
`timescale 1ns/100ps
module tsec_core_top
	import tsec_pkg::*;
(
	input  wire logic               ref_clk,              // Core clock
	input  wire logic               resetn,               // Async reset, active low
	input  wire logic [NUM_SRC-1:0] periph_irq,           // Peripheral lines, async
	input  wire logic [NUM_DED-1:0] dedicated_event,      // Levels 0..6, async
	input  wire logic               global_irq_on_instr,  // Global enable pulse
	input  wire logic               global_irq_off_instr, // Global disable pulse
	input  wire logic               entry_allow,          // Pipeline takes an event
	input  wire logic               event_return,         // Return-from-event pulse
	input  wire logic [3:0]         event_return_level,   // Level being returned
	input  wire logic               core_idle,            // Core is idled
	output tsec_entry_s             event_entry,          // Entry pulse and level
	output logic      [NUM_EVT-1:0] event_nest_pending,   // Nesting-pending bits
	output logic                    wake_req,             // Wake the processor
	input  wire logic               s_axi_awvalid,        // Write address valid
	output logic                    s_axi_awready,        // Write address ready
	input  wire logic [11:0]        s_axi_awaddr,         // Write byte address
	input  wire logic [2:0]         s_axi_awprot,         // Bit 0 = privileged
	input  wire logic               s_axi_wvalid,         // Write data valid
	output logic                    s_axi_wready,         // Write data ready
	input  wire logic [31:0]        s_axi_wdata,          // Write data
	input  wire logic [3:0]         s_axi_wstrb,          // Byte strobes
	output logic                    s_axi_bvalid,         // Write response valid
	input  wire logic               s_axi_bready,         // Write response ready
	output logic      [1:0]         s_axi_bresp,          // Write response
	input  wire logic               s_axi_arvalid,        // Read address valid
	output logic                    s_axi_arready,        // Read address ready
	input  wire logic [11:0]        s_axi_araddr,         // Read byte address
	input  wire logic [2:0]         s_axi_arprot,         // Bit 0 = privileged
	output logic                    s_axi_rvalid,         // Read data valid
	input  wire logic               s_axi_rready,         // Read data ready
	output logic      [31:0]        s_axi_rdata,          // Read data
	output logic      [1:0]         s_axi_rresp           // Read response
);

	// ----------------------------------------------------------------
	// Reset release and pin synchronisers
	// ----------------------------------------------------------------
	logic               rst_meta;
	logic               rst_n;
	logic [NUM_SRC-1:0] src_meta;
	logic [NUM_SRC-1:0] src_sync;
	logic [NUM_SRC-1:0] src_prev;
	logic [NUM_DED-1:0] ded_meta;
	logic [NUM_DED-1:0] ded_sync;

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			rst_meta <= 1'b0;
			rst_n    <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n    <= rst_meta;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			src_meta <= '0;
			src_sync <= '0;
			src_prev <= '0;
			ded_meta <= '0;
			ded_sync <= '0;
		end else begin
			src_meta <= periph_irq;
			src_sync <= src_meta;
			src_prev <= src_sync;
			ded_meta <= dedicated_event;
			ded_sync <= ded_meta;
		end
	end

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	logic [31:0]        periph_mask;
	logic [31:0]        wake_en;
	logic [31:0]        irq_assignment [NUM_ASSIGN_REG];
	logic [NUM_SRC-1:0] forwarded;
	logic [NUM_EVT-1:0] core_event_mask;
	logic [NUM_EVT-1:0] event_latch;
	logic [NUM_EVT-1:0] pend_q;
	logic [NUM_EVT-1:0] enable_q;
	logic               global_en;
	logic [31:0]        next_periph_mask;
	logic [31:0]        next_wake_en;
	logic [31:0]        next_irq_assignment [NUM_ASSIGN_REG];
	logic [NUM_SRC-1:0] next_forwarded;
	logic [NUM_EVT-1:0] next_core_event_mask;
	logic [NUM_EVT-1:0] next_event_latch;
	logic [NUM_EVT-1:0] next_pending;
	logic               next_global_en;
	tsec_entry_s        next_entry;
	logic               next_wake;

	// ----------------------------------------------------------------
	// Peripheral stage routing
	// ----------------------------------------------------------------
	logic [ASSIGN_W-1:0] src_lvl [NUM_SRC];
	logic [NUM_GP-1:0]   src_sel [NUM_SRC];
	logic [NUM_SRC-1:0]  src_ack;
	logic [NUM_SRC-1:0]  src_rise;
	logic [NUM_GP-1:0]   gp_line;
	logic [NUM_EVT-1:0]  pend_rise;

	assign pend_rise = event_nest_pending & ~pend_q;
	assign src_rise  = src_sync & ~src_prev & periph_mask;

	genvar g;
	for (g = 0; g < NUM_SRC; g++) begin : g_route
		assign src_lvl[g] = irq_assignment[g / SRC_PER_ASSIGN]
			[(g % SRC_PER_ASSIGN) * ASSIGN_W +: ASSIGN_W];
		assign src_sel[g] = GP_ONE << src_lvl[g];
		assign src_ack[g] = |(pend_rise[NUM_EVT-1:GP_FIRST] & src_sel[g]);
	end

	// Sources that share a level merge here, so simultaneous pulses fold into one edge
	// peripheral mask gate
	always_comb begin
		gp_line = '0;
		for (int s = 0; s < NUM_SRC; s++) begin
			if (src_sync[s] && periph_mask[s]) begin
				gp_line = gp_line | src_sel[s];
			end
		end
	end

	logic [NUM_EVT-1:0] ev_raw;
	logic [NUM_EVT-1:0] ev_rise;

	assign ev_raw = {gp_line, ded_sync} & EVT_VALID;

	tsec_edge_detect #(
		.W (NUM_EVT)
	) u_edge (
		.clk      (ref_clk),
		.rst_n    (rst_n),
		.level_in (ev_raw),
		.rise     (ev_rise)
	);

	// ----------------------------------------------------------------
	// Core stage priority resolution
	// ----------------------------------------------------------------
	logic [NUM_EVT-1:0] core_mask_eff;
	logic [NUM_EVT-1:0] enable_vec;
	logic [NUM_EVT-1:0] cand;
	logic               found;
	logic               pick;
	logic [3:0]         pick_lvl;

	assign core_mask_eff = core_event_mask | DED_UNMASKED;

	// lowest index wins; an active level blocks itself and all below it
	always_comb begin
		enable_vec = core_mask_eff & (global_en ? {NUM_EVT{1'b1}} : ~GP_LEVELS);
		cand       = event_latch & enable_vec;
		found      = 1'b0;
		pick       = 1'b0;
		pick_lvl   = 4'h0;
		for (int i = 0; i < NUM_EVT; i++) begin
			if (!found) begin
				if (event_nest_pending[i]) begin
					found = 1'b1;
				end else if (cand[i]) begin
					found    = 1'b1;
					pick     = entry_allow;
					pick_lvl = 4'(i);
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Bus slave
	// ----------------------------------------------------------------
	tsec_wr_e    wstate;
	tsec_wr_e    next_wstate;
	logic        aw_held;
	logic [11:0] aw_addr;
	logic        aw_priv;
	logic        w_held;
	logic [31:0] w_data;
	logic [3:0]  w_strb;
	logic        next_aw_held;
	logic [11:0] next_aw_addr;
	logic        next_aw_priv;
	logic        next_w_held;
	logic [31:0] next_w_data;
	logic [3:0]  next_w_strb;
	logic        next_awready;
	logic        next_wready;
	logic        next_bvalid;
	logic [1:0]  next_bresp;
	logic        next_arready;
	logic        next_rvalid;
	logic [31:0] next_rdata;
	logic [1:0]  next_rresp;
	logic        do_write;
	logic [11:0] wr_word;
	logic [1:0]  wr_resp;
	logic [31:0] wmask;
	logic [31:0] rd_val;
	logic [11:0] rd_word;

	// Core registers answer privileged accesses only; others are refused with SLVERR
	function automatic logic [1:0] addr_resp(input logic [11:0] w, input logic priv);
		logic [1:0] r;
		r = RESP_OKAY;
		case (w)
			OFS_PERIPH_MASK, OFS_PERIPH_STATUS, OFS_PERIPH_WAKE, OFS_FORWARDED,
			OFS_GLOBAL_EN: r = RESP_OKAY;
			OFS_CORE_LATCH, OFS_CORE_MASK, OFS_CORE_PENDING: r = priv ? RESP_OKAY : RESP_SLVERR;
			default: r = (w[11:4] == OFS_ASSIGN0[11:4]) ? RESP_OKAY : RESP_DECERR;
		endcase
		return r;
	endfunction : addr_resp

	assign wr_word  = {aw_addr[11:2], 2'b00};
	assign rd_word  = {s_axi_araddr[11:2], 2'b00};
	assign do_write = (wstate == WR_IDLE) && aw_held && w_held;
	assign wr_resp  = addr_resp(wr_word, aw_priv);

	always_comb begin
		for (int b = 0; b < 4; b++) begin
			wmask[b*8 +: 8] = {8{w_strb[b]}};
		end
	end

	always_comb begin
		case (rd_word)
			OFS_PERIPH_MASK:   rd_val = periph_mask;
			OFS_PERIPH_STATUS: rd_val = src_sync;
			OFS_PERIPH_WAKE:   rd_val = wake_en;
			OFS_FORWARDED:     rd_val = forwarded;
			OFS_CORE_LATCH:    rd_val = {16'h0, event_latch};
			OFS_CORE_MASK:     rd_val = {16'h0, core_mask_eff};
			OFS_CORE_PENDING:  rd_val = {16'h0, event_nest_pending};
			OFS_GLOBAL_EN:     rd_val = {31'h0, global_en};
			default: begin
				rd_val = (rd_word[11:4] == OFS_ASSIGN0[11:4]) ?
					irq_assignment[rd_word[3:2]] : 32'h0;
			end
		endcase
		if (addr_resp(rd_word, s_axi_arprot[0]) != RESP_OKAY) begin
			rd_val = 32'h0;
		end
	end

	always_comb begin
		next_wstate  = wstate;
		next_aw_held = aw_held;
		next_aw_addr = aw_addr;
		next_aw_priv = aw_priv;
		next_w_held  = w_held;
		next_w_data  = w_data;
		next_w_strb  = w_strb;
		next_bvalid  = s_axi_bvalid;
		next_bresp   = s_axi_bresp;
		next_rvalid  = s_axi_rvalid;
		next_rdata   = s_axi_rdata;
		next_rresp   = s_axi_rresp;
		if (s_axi_awvalid && s_axi_awready) begin
			next_aw_held = 1'b1;
			next_aw_addr = s_axi_awaddr;
			next_aw_priv = s_axi_awprot[0];
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_w_held = 1'b1;
			next_w_data = s_axi_wdata;
			next_w_strb = s_axi_wstrb;
		end
		case (wstate)
			WR_IDLE: begin
				if (aw_held && w_held) begin
					next_wstate  = WR_RESP;
					next_bvalid  = 1'b1;
					next_bresp   = wr_resp;
					next_aw_held = 1'b0;
					next_w_held  = 1'b0;
				end
			end
			WR_RESP: begin
				if (s_axi_bready) begin
					next_wstate = WR_IDLE;
					next_bvalid = 1'b0;
				end
			end
			default: next_wstate = WR_IDLE;
		endcase
		if (s_axi_rvalid && s_axi_rready) begin
			next_rvalid = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			next_rvalid = 1'b1;
			next_rdata  = rd_val;
			next_rresp  = addr_resp(rd_word, s_axi_arprot[0]);
		end
		next_awready = !next_aw_held;
		next_wready  = !next_w_held;
		next_arready = !next_rvalid;
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			wstate        <= WR_IDLE;
			aw_held       <= 1'b0;
			aw_addr       <= 12'h0;
			aw_priv       <= 1'b0;
			w_held        <= 1'b0;
			w_data        <= 32'h0;
			w_strb        <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= RESP_OKAY;
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0;
			s_axi_rresp   <= RESP_OKAY;
		end else begin
			wstate        <= next_wstate;
			aw_held       <= next_aw_held;
			aw_addr       <= next_aw_addr;
			aw_priv       <= next_aw_priv;
			w_held        <= next_w_held;
			w_data        <= next_w_data;
			w_strb        <= next_w_strb;
			s_axi_awready <= next_awready;
			s_axi_wready  <= next_wready;
			s_axi_bvalid  <= next_bvalid;
			s_axi_bresp   <= next_bresp;
			s_axi_arready <= next_arready;
			s_axi_rvalid  <= next_rvalid;
			s_axi_rdata   <= next_rdata;
			s_axi_rresp   <= next_rresp;
		end
	end

	// ----------------------------------------------------------------
	// Register and event state update
	// ----------------------------------------------------------------
	logic [NUM_EVT-1:0] sw_clr;
	logic [NUM_EVT-1:0] enter_bit;
	logic [NUM_EVT-1:0] ret_bit;

	always_comb begin
		next_periph_mask     = periph_mask;
		next_wake_en         = wake_en;
		next_irq_assignment  = irq_assignment;
		next_core_event_mask = core_event_mask;
		next_global_en       = global_en;
		sw_clr               = '0;
		if (do_write && wr_resp == RESP_OKAY) begin
			case (wr_word)
				OFS_PERIPH_MASK: next_periph_mask = (periph_mask & ~wmask) | (w_data & wmask);
				OFS_PERIPH_WAKE: next_wake_en = (wake_en & ~wmask) | (w_data & wmask);
				// writing zero cancels only where masked
				OFS_CORE_LATCH:  sw_clr = wmask[15:0] & ~w_data[15:0] & ~core_mask_eff;
				OFS_CORE_MASK: begin
					next_core_event_mask = (core_event_mask & ~wmask[15:0]) |
						(w_data[15:0] & wmask[15:0]);
				end
				default: begin
					if (wr_word[11:4] == OFS_ASSIGN0[11:4]) begin
						next_irq_assignment[wr_word[3:2]] =
							(irq_assignment[wr_word[3:2]] & ~wmask) | (w_data & wmask);
					end
				end
			endcase
		end
		if (global_irq_off_instr) begin
			next_global_en = 1'b0;
		end else if (global_irq_on_instr) begin
			next_global_en = 1'b1;
		end
		enter_bit = pick ? (EVT_ONE << pick_lvl) : '0;
		ret_bit   = event_return ? (EVT_ONE << event_return_level) : '0;
		// entry clears latch, a new edge sets it again and wins
		next_event_latch = (event_latch & ~enter_bit & ~sw_clr) | ev_rise;
		next_pending = (event_nest_pending & ~ret_bit) | enter_bit;
		next_forwarded = (forwarded & ~src_ack) | src_rise;
		next_entry.valid = pick;
		next_entry.level = pick_lvl;
		next_wake = core_idle && |(src_sync & wake_en);
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			periph_mask        <= RST_PERIPH_MASK;
			wake_en            <= RST_PERIPH_WAKE;
			for (int k = 0; k < NUM_ASSIGN_REG; k++) begin
				irq_assignment[k] <= RST_ASSIGN;
			end
			core_event_mask    <= RST_CORE_MASK;
			global_en          <= RST_GLOBAL_EN;
			event_latch        <= '0;
			event_nest_pending <= '0;
			pend_q             <= '0;
			enable_q           <= '0;
			forwarded          <= '0;
			event_entry        <= '0;
			wake_req           <= 1'b0;
		end else begin
			periph_mask        <= next_periph_mask;
			wake_en            <= next_wake_en;
			irq_assignment     <= next_irq_assignment;
			core_event_mask    <= next_core_event_mask;
			global_en          <= next_global_en;
			event_latch        <= next_event_latch;
			event_nest_pending <= next_pending;
			pend_q             <= event_nest_pending;
			enable_q           <= enable_vec;
			forwarded          <= next_forwarded;
			event_entry        <= next_entry;
			wake_req           <= next_wake;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	a_latch_sw_guard: assert property (
		(($past(event_latch) & ~event_latch & $past(core_mask_eff) & ~event_nest_pending)
			== 16'h0))
		else $error("masked-in latch bit lost without entry");
	a_entry_enabled: assert property (
		event_entry.valid |-> enable_q[event_entry.level])
		else $error("entry for disabled event");
	a_entry_pending: assert property (
		event_entry.valid |-> event_nest_pending[event_entry.level])
		else $error("entry without pending bit");
	a_mask_write_priv: assert property (
		$changed(core_event_mask) |-> $past(do_write && aw_priv && wr_word == OFS_CORE_MASK))
		else $error("core mask changed without privileged write");
	a_global_off: assert property (
		global_irq_off_instr |=> !global_en)
		else $error("global enable survived disable");
	a_periph_block: assert property (
		(periph_mask == 32'h0) |-> (gp_line == 9'h0))
		else $error("masked source reached core input");
	a_edge_latch: assert property (
		$rose(ev_raw[7]) |-> ##2 event_latch[7])
		else $error("edge not latched after two cycles");
	a_min_latency: assert property (
		($rose(ev_raw[7]) && !event_latch[7] && !event_nest_pending[7]) |->
			##1 !event_nest_pending[7] ##1 !event_nest_pending[7])
		else $error("pending asserted too early");
	a_return_clear: assert property (
		event_return |=> !event_nest_pending[$past(event_return_level)])
		else $error("return did not clear pending");
	a_nest_priority: assert property (
		event_entry.valid |-> (($past(event_nest_pending) &
			((EVT_ONE << event_entry.level) | ((EVT_ONE << event_entry.level) - 16'h1)))
			== 16'h0))
		else $error("entry under higher active level");

	c_nested_entry: cover property (
		event_entry.valid && (event_nest_pending & ~(EVT_ONE << event_entry.level)) != 16'h0);
	c_queued_edge: cover property (event_nest_pending[7] && ev_rise[7]);
	c_wake: cover property (wake_req);
	c_sw_cancel: cover property (sw_clr != 16'h0 && (event_latch & sw_clr) != 16'h0);

endmodule : tsec_core_top

// >>> tsec_pipe_model.sv
// Pipeline model: takes an event, returns from it after a hold
`timescale 1ns/100ps
module tsec_pipe_model
	import tsec_pkg::*;
#(
	parameter int HOLD = 40
) (
	input  wire logic        ref_clk,            // Core clock
	input  wire tsec_entry_s event_entry,        // Entry from controller
	output logic             entry_allow,        // Pipeline accepts
	output logic             event_return,       // Return pulse
	output logic [3:0]       event_return_level  // Level returned
);
	int cnt = 0;
	initial begin
		entry_allow = 1'b0;
		event_return = 1'b0;
		event_return_level = 4'h0;
	end
	always @(posedge ref_clk) begin
		entry_allow <= (cnt != HOLD);
		event_return <= (cnt == 1);
		if (event_entry.valid) begin
			event_return_level <= event_entry.level;
			cnt <= HOLD;
		end else if (cnt > 0) begin
			cnt <= cnt - 1;
		end
	end
endmodule : tsec_pipe_model

// >>> two_stage_event_controller_test.sv
// Bench for the two-stage event controller
`timescale 1ns/100ps
module two_stage_event_controller_test;
	import tsec_pkg::*;
	logic        ref_clk = 0, resetn = 0, aw = 0, w = 0, br = 0, ar = 0, rr = 0;
	logic        idle = 0, on = 0, off = 0, awr, wr, bv, arr, rv, ea, er, wake;
	logic [6:0]  ded = 0;
	logic [31:0] irq = 0, wd = 0, rdata;
	logic [11:0] awa = 0, ara = 0;
	logic [2:0]  awp = 0, arp = 0;
	logic [1:0]  bresp, rresp;
	logic [3:0]  erl, lvl;
	logic [15:0] pend;
	tsec_entry_s ent;
	int          errors = 0, num_checks = 0, nent = 0;
	always #4 ref_clk = ~ref_clk;
	tsec_core_top u_tsec_core_top(.ref_clk, .resetn, .periph_irq(irq), .dedicated_event(ded),
		.global_irq_on_instr(on), .global_irq_off_instr(off), .entry_allow(ea),
		.event_return(er), .event_return_level(erl), .core_idle(idle), .event_entry(ent),
		.event_nest_pending(pend), .wake_req(wake), .s_axi_awvalid(aw), .s_axi_awready(awr),
		.s_axi_awaddr(awa), .s_axi_awprot(awp), .s_axi_wvalid(w), .s_axi_wready(wr),
		.s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_bvalid(bv), .s_axi_bready(br),
		.s_axi_bresp(bresp), .s_axi_arvalid(ar), .s_axi_arready(arr), .s_axi_araddr(ara),
		.s_axi_arprot(arp), .s_axi_rvalid(rv), .s_axi_rready(rr), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp));
	tsec_pipe_model u_tsec_pipe_model(.ref_clk, .event_entry(ent), .entry_allow(ea),
		.event_return(er), .event_return_level(erl));
	always @(posedge ref_clk) if (ent.valid === 1'b1) begin
		nent++;
		lvl = ent.level;
	end
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		num_checks++;
		if (s !== e) begin
			errors++;
			$display("[ERR] %0t seen %h expected %h", $time, s, e);
		end
	endtask : chk
	task automatic report_and_stop;
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : report_and_stop
	task automatic bound(input int n);
		if (n >= 99) begin
			errors++;
			report_and_stop();
		end
	endtask : bound
	task automatic wr32(input logic [11:0] a, input logic [31:0] d, input logic [1:0] e);
		int n;
		logic ta, tw;
		n = 0;
		ta = 0;
		tw = 0;
		@(posedge ref_clk);
		aw <= 1;
		w <= 1;
		br <= 1;
		awa <= a;
		wd <= d;
		awp <= 3'h1;
		do begin
			@(posedge ref_clk);
			n++;
			if (awr) aw <= 0;
			if (wr) w <= 0;
			ta = ta | awr;
			tw = tw | wr;
		end while (!(ta && tw) && n < 99);
		do begin
			@(posedge ref_clk);
			n++;
		end while (!bv && n < 99);
		br <= 0;
		bound(n);
		chk({30'h0, bresp}, e);
	endtask : wr32
	task automatic rd32(input logic [11:0] a, input logic p, input logic [31:0] d,
		input logic [1:0] e);
		int n;
		n = 0;
		@(posedge ref_clk);
		ar <= 1;
		rr <= 1;
		ara <= a;
		arp <= {2'h0, p};
		do begin
			@(posedge ref_clk);
			n++;
		end while (!arr && n < 99);
		ar <= 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (!rv && n < 99);
		rr <= 0;
		bound(n);
		chk(rdata, d);
		chk({30'h0, rresp}, e);
	endtask : rd32
	task automatic wait_ent(input int k, output int n);
		n = 0;
		while (nent < k && n < 99) begin
			@(negedge ref_clk);
			n++;
		end
		bound(n);
		@(posedge ref_clk);
	endtask : wait_ent
	task automatic s_regs;
		rd32(OFS_PERIPH_MASK, 1, 0, RESP_OKAY);
		rd32(OFS_PERIPH_WAKE, 1, 0, RESP_OKAY);
		rd32(OFS_CORE_MASK, 1, 32'hf, RESP_OKAY);
		rd32(OFS_CORE_MASK, 0, 0, RESP_SLVERR);
		rd32(OFS_CORE_PENDING, 0, 0, RESP_SLVERR);
		rd32(12'h100, 1, 0, RESP_DECERR);
		wr32(OFS_PERIPH_MASK, 32'h3, RESP_OKAY);
		rd32(OFS_PERIPH_MASK, 1, 32'h3, RESP_OKAY);
	endtask : s_regs
	task automatic s_service;
		int n;
		wr32(OFS_CORE_MASK, 32'h80, RESP_OKAY);
		on <= 1;
		@(posedge ref_clk);
		on <= 0;
		irq[0] <= 1;
		wait_ent(1, n);
		chk({28'h0, lvl}, 32'h7);
		chk({31'h0, n >= 3}, 32'h1);
		rd32(OFS_CORE_PENDING, 1, 32'h80, RESP_OKAY);
		rd32(OFS_CORE_LATCH, 1, 0, RESP_OKAY);
		rd32(OFS_PERIPH_STATUS, 1, 32'h1, RESP_OKAY);
		irq[0] <= 0;
		repeat (4) @(posedge ref_clk);
		irq[0] <= 1;
		repeat (8) @(posedge ref_clk);
		rd32(OFS_CORE_LATCH, 1, 32'h80, RESP_OKAY);
		wait_ent(2, n);
		chk({28'h0, lvl}, 32'h7);
		repeat (60) @(posedge ref_clk);
		chk({16'h0, pend}, 0);
	endtask : s_service
	task automatic s_blocked;
		irq[0] <= 0;
		wr32(OFS_CORE_MASK, 0, RESP_OKAY);
		irq[1] <= 1;
		repeat (20) @(posedge ref_clk);
		chk(nent, 2);
		rd32(OFS_CORE_LATCH, 1, 32'h80, RESP_OKAY);
		rd32(OFS_FORWARDED, 1, 32'h2, RESP_OKAY);
		irq[1] <= 0;
		wr32(OFS_CORE_LATCH, 0, RESP_OKAY);
		rd32(OFS_CORE_LATCH, 1, 0, RESP_OKAY);
		irq[2] <= 1;
		repeat (20) @(posedge ref_clk);
		rd32(OFS_CORE_LATCH, 1, 0, RESP_OKAY);
	endtask : s_blocked
	task automatic s_wake;
		idle <= 1;
		wr32(OFS_PERIPH_WAKE, 32'h4, RESP_OKAY);
		repeat (5) @(posedge ref_clk);
		chk({31'h0, wake}, 32'h1);
		idle <= 0;
		repeat (3) @(posedge ref_clk);
		chk({31'h0, wake}, 0);
	endtask : s_wake
	task automatic s_route;
		int n;
		wr32(OFS_ASSIGN0, 32'h10, RESP_OKAY);
		wr32(OFS_CORE_MASK, 32'h140, RESP_OKAY);
		irq[1] <= 1;
		ded <= 7'h40;
		wait_ent(3, n);
		chk({28'h0, lvl}, 32'h6);
		wr32(OFS_CORE_LATCH, 0, RESP_OKAY);
		wait_ent(4, n);
		chk({28'h0, lvl}, 32'h8);
		rd32(OFS_CORE_PENDING, 1, 32'h100, RESP_OKAY);
	endtask : s_route
	task automatic s_global;
		rd32(OFS_GLOBAL_EN, 0, 32'h1, RESP_OKAY);
		on <= 1;
		off <= 1;
		@(posedge ref_clk);
		on <= 0;
		off <= 0;
		rd32(OFS_GLOBAL_EN, 0, 0, RESP_OKAY);
	endtask : s_global
	initial begin
		repeat (4) @(posedge ref_clk);
		resetn <= 1;
		repeat (3) @(posedge ref_clk);
		s_regs();
		s_service();
		s_blocked();
		s_wake();
		s_route();
		s_global();
		report_and_stop();
	end
endmodule : two_stage_event_controller_test
